// ---- dse_eeprom.sv ----
// EEPROM array with self-timed programming.
// Assumes requests only arrive from the access logic in dse_top.
`timescale 1ns/1ps
module dse_eeprom #(
  parameter int PROG_CYCLES = dse_pkg::DSE_PROG_CYCLES
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // Access
  input  wire logic [dse_pkg::DSE_EE_AW-1:0] addr,
  input  wire logic                          rd,
  input  wire logic                          wr,
  input  wire logic [7:0]                    wdata,
  output logic      [7:0]                    rdata,
  output logic                               busy
);
  import dse_pkg::*;

  logic [7:0]       mem [DSE_EE_BYTES];
  logic [7:0]       next_rdata;
  logic [31:0]      cnt;
  logic [31:0]      next_cnt;
  dse_ee_state_type state;
  dse_ee_state_type next_state;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_rdata = rdata;
    if (rd && state == DSE_EE_IDLE) begin
      next_rdata = mem[addr]; // R7 R18
    end
    case (state)
      DSE_EE_IDLE: begin
        if (wr) begin
          next_state = DSE_EE_PROG;
          next_cnt   = 32'(PROG_CYCLES - 1);
        end
      end
      DSE_EE_PROG: begin
        if (cnt == 32'h0) begin
          next_state = DSE_EE_IDLE; // R10
        end else begin
          next_cnt = cnt - 32'h1;
        end
      end
      default: next_state = DSE_EE_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= DSE_EE_IDLE;
      cnt   <= 32'h0;
      rdata <= 8'h00;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      rdata <= next_rdata;
    end
  end

  // Array has no reset; content survives reset like the real cells
  always_ff @(posedge clk) begin
    if (wr && state == DSE_EE_IDLE) begin
      mem[addr] <= wdata; // R7
    end
  end

  assign busy = (state == DSE_EE_PROG);

  prog_time_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(busy) |-> busy [*8]) else $error("Programming ended too early"); // R10
endmodule // dse_eeprom

// ---- dse_pkg.sv ----
// Package for the data-space decoder and data EEPROM access block.
// Assumes a single 20 MHz core clock and an active-low asynchronous reset.
package dse_pkg;
  // Data-space map
  localparam logic [15:0] DSE_REGFILE_END = 16'h001f;
  localparam logic [15:0] DSE_STDIO_BASE  = 16'h0020;
  localparam logic [15:0] DSE_STDIO_END   = 16'h005f;
  localparam logic [15:0] DSE_EXTIO_BASE  = 16'h0060;
  localparam logic [15:0] DSE_EXTIO_END   = 16'h00ff;
  localparam logic [15:0] DSE_SRAM_BASE   = 16'h0100;
  localparam int          DSE_SRAM_BYTES  = 1024;
  localparam int          DSE_SRAM_AW     = 10;
  localparam logic [5:0]  DSE_DISP_MAX    = 6'h3f;
  // EEPROM space
  localparam int          DSE_EE_BYTES    = 512;
  localparam int          DSE_EE_AW       = 9;
  // I/O offsets of the access registers (standard I/O space numbering)
  localparam logic [5:0]  DSE_IO_CTRL     = 6'h1f;
  localparam logic [5:0]  DSE_IO_DATA     = 6'h20;
  localparam logic [5:0]  DSE_IO_ADDR_LO  = 6'h21;
  localparam logic [5:0]  DSE_IO_ADDR_HI  = 6'h22;
  // Control bit positions
  localparam int          DSE_BIT_READ    = 0;
  localparam int          DSE_BIT_WRITE   = 1;
  localparam int          DSE_BIT_ARM     = 2;
  // Timing
  localparam int          DSE_CLK_HZ      = 20_000_000;
  localparam int          DSE_ARM_CYCLES  = 4;
  localparam int          DSE_RD_STALL    = 4;
  localparam int          DSE_WR_STALL    = 2;
  localparam int          DSE_SRAM_CYC    = 2;
  localparam int          DSE_PROG_US     = 3300;
  localparam int          DSE_PROG_CYCLES = (DSE_PROG_US * (DSE_CLK_HZ / 1_000_000));
  localparam logic [7:0]  DSE_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  DSE_DATA_RESET  = 8'h00;

  typedef enum logic [1:0] {
    DSE_AM_DIRECT = 2'h0,
    DSE_AM_DISP   = 2'h1,
    DSE_AM_PREDEC = 2'h2,
    DSE_AM_POSTINC= 2'h3
  } dse_mode_type;

  typedef enum logic [1:0] {
    DSE_PTR_X = 2'h0,
    DSE_PTR_Y = 2'h1,
    DSE_PTR_Z = 2'h2
  } dse_ptr_type;

  typedef struct packed {
    logic         valid;
    logic         write;
    logic         short_io;
    dse_mode_type mode;
    dse_ptr_type  ptr;
    logic [15:0]  addr;
    logic [5:0]   disp;
    logic [7:0]   wdata;
  } dse_req_type;

  typedef enum logic [1:0] {
    DSE_EE_IDLE  = 2'b00,
    DSE_EE_PROG  = 2'b01
  } dse_ee_state_type;
endpackage

// ---- dse_regfile_model.sv ----
// Far-side model: register file and I/O bytes reached through the ext_* ports.
// Assumes ext_addr selects the byte for reads as well as writes.
`timescale 1ns/1ps
module dse_regfile_model (
  // Clock
  input  wire logic       clk,
  // Access
  input  wire logic       ext_we,
  input  wire logic [7:0] ext_addr,
  input  wire logic [7:0] ext_wdata,
  output logic      [7:0] ext_rdata
);
  logic [7:0] mem [256];
  // Seeded with a pattern so that a stale read differs from a fresh one
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  always @(posedge clk) if (ext_we) mem[ext_addr] <= ext_wdata;
  assign ext_rdata = mem[ext_addr];
endmodule // dse_regfile_model

// ---- dse_top.sv ----
// Data-space decoder, SRAM and EEPROM access registers for an 8-bit core.
// Assumes the core holds a request stable while stall is high.
// Operation
// R1 - Decode register file, standard I/O, extended I/O, then SRAM, in order.
// R2 - Extended I/O reachable only by load/store, not short in/out forms.
// R3 - Displacement mode adds up to 63 to the Y or Z pointer.
// R4 - Pre-decrement before use, post-increment after use, written back to pointer.
// R5 - Direct addressing reaches every data-space location.
// R6 - Every SRAM access takes two core clock cycles.
// R7 - Separate 512-byte EEPROM with independent byte read and write.
// R8 - EEPROM address, data and control registers sit in I/O space.
// R9 - EEPROM read stalls core four cycles; write stalls two.
// R10 - Writes self-timed; write strobe polls busy status.
// R11 - Software uses the arm-then-strobe sequence to start writes.
// R12 - Address high byte: bit 8 writable, upper seven read zero.
// R13 - Write starts only if strobe follows arm within four cycles; arm self-clears.
// R14 - Hardware clears write strobe when programming time has elapsed.
// R15 - During programming, reads ignored and address register frozen.
// R16 - Nine-bit address linearly selects one EEPROM byte.
// R17 - Accesses above SRAM end store nothing and read zero.
// R18 - EEPROM read data lands in the data register within the stall.
`timescale 1ns/1ps
module dse_top #(
  parameter int PROG_CYCLES = dse_pkg::DSE_PROG_CYCLES
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Core request
  input  wire dse_pkg::dse_req_type req,
  // Pointer registers from the register file
  input  wire logic [15:0]          ptr_x,
  input  wire logic [15:0]          ptr_y,
  input  wire logic [15:0]          ptr_z,
  // Answer
  output logic      [7:0]           rdata,
  output logic                      done,
  output logic                      stall,
  // Pointer write-back
  output logic                      ptr_we,
  output dse_pkg::dse_ptr_type      ptr_sel,
  output logic      [15:0]          ptr_val,
  // Register-file, standard and extended I/O ports outside this block
  output logic                      ext_we,
  output logic      [7:0]           ext_addr,
  output logic      [7:0]           ext_wdata,
  input  wire logic [7:0]           ext_rdata,
  // EEPROM status
  output logic                      ee_busy
);
  import dse_pkg::*;

  logic [7:0]  sram [DSE_SRAM_BYTES];
  logic [15:0] base;
  logic [15:0] ea;
  logic [15:0] ptr_new;
  logic        hit_ext;
  logic        hit_extio;
  logic        hit_sram;
  logic        hit_ee;
  logic        ext_rd;
  logic [5:0]  io_off;
  logic        phase;
  logic        next_phase;
  logic [7:0]  next_rdata;
  logic        next_done;
  logic [7:0]  ee_data;
  logic [7:0]  next_ee_data;
  logic [8:0]  ee_addr;
  logic [8:0]  next_ee_addr;
  logic [2:0]  arm_cnt;
  logic [2:0]  next_arm_cnt;
  logic [2:0]  stall_cnt;
  logic [2:0]  next_stall_cnt;
  logic        ee_rd;
  logic        ee_wr;
  logic        io_we;
  logic [7:0]  ee_rdata;
  logic        arr_busy;
  logic        wr_pend;
  logic        next_wr_pend;
  logic        rd_pend;
  logic        next_rd_pend;

  // Address formation
  always_comb begin
    case (req.ptr)
      DSE_PTR_X: base = ptr_x;
      DSE_PTR_Y: base = ptr_y;
      DSE_PTR_Z: base = ptr_z;
      default:   base = ptr_z;
    endcase
    case (req.mode)
      DSE_AM_DIRECT:  ea = req.addr; // R5
      DSE_AM_DISP:    ea = base + {10'h000, req.disp}; // R3
      DSE_AM_PREDEC:  ea = base - 16'h0001; // R4
      DSE_AM_POSTINC: ea = base;
      default:        ea = base;
    endcase
    if (req.short_io) begin
      ea = DSE_STDIO_BASE + {10'h000, req.addr[5:0]}; // R2
    end
    ptr_new   = (req.mode == DSE_AM_PREDEC) ? ea : base + 16'h0001; // R4
    hit_ext   = (ea <= DSE_STDIO_END); // R1
    hit_extio = (ea >= DSE_EXTIO_BASE) && (ea <= DSE_EXTIO_END) && !req.short_io; // R1 R2
    hit_sram  = (ea >= DSE_SRAM_BASE) && (ea < DSE_SRAM_BASE + 16'(DSE_SRAM_BYTES)); // R1 R17
    io_off    = 6'(ea - DSE_STDIO_BASE);
    hit_ee    = (ea >= DSE_STDIO_BASE) && (ea <= DSE_STDIO_END)
                && (io_off >= DSE_IO_CTRL) && (io_off <= DSE_IO_ADDR_HI); // R8
    // ext_addr is registered, so an outside read needs a phase for it to lead the data
    ext_rd    = !req.write && (hit_ext || hit_extio) && !hit_ee;
  end

  // Access timing: SRAM accesses and outside reads take a second phase, others finish in one
  always_comb begin
    next_phase = 1'b0;
    next_done  = 1'b0;
    next_rdata = rdata;
    if (req.valid && stall_cnt == 3'h0 && !done) begin
      if ((hit_sram || ext_rd) && !phase) begin
        next_phase = 1'b1; // R6
      end else begin
        next_done = 1'b1;
        if (req.write) begin
          next_rdata = rdata;
        end else if (hit_ee) begin
          case (io_off)
            DSE_IO_CTRL:    next_rdata = {5'h00, arm_cnt != 3'h0, ee_busy, 1'b0};
            DSE_IO_DATA:    next_rdata = ee_data;
            DSE_IO_ADDR_LO: next_rdata = ee_addr[7:0];
            default:        next_rdata = {7'h00, ee_addr[8]}; // R12
          endcase
        end else if (hit_ext) begin
          next_rdata = ext_rdata;
        end else if (hit_sram) begin
          next_rdata = sram[10'(ea - DSE_SRAM_BASE)]; // R6
        end else if (hit_extio) begin
          next_rdata = ext_rdata;
        end else begin
          next_rdata = 8'h00; // R17
        end
      end
    end
  end

  assign io_we = next_done && req.write && hit_ee;

  // EEPROM control
  always_comb begin
    next_ee_data   = ee_data;
    next_ee_addr   = ee_addr;
    next_arm_cnt   = (arm_cnt != 3'h0) ? arm_cnt - 3'h1 : 3'h0; // R13
    next_stall_cnt = (stall_cnt != 3'h0) ? stall_cnt - 3'h1 : 3'h0;
    next_wr_pend   = wr_pend;
    next_rd_pend   = 1'b0;
    ee_rd          = 1'b0;
    ee_wr          = 1'b0;
    if (wr_pend && !arr_busy) begin
      ee_wr        = 1'b1;
      next_wr_pend = 1'b0;
    end
    if (rd_pend) begin
      next_ee_data = ee_rdata; // R18
    end
    if (io_we) begin
      case (io_off)
        DSE_IO_CTRL: begin
          if (req.wdata[DSE_BIT_ARM] && !req.wdata[DSE_BIT_WRITE]) begin
            next_arm_cnt = 3'(DSE_ARM_CYCLES); // R13
          end
          if (req.wdata[DSE_BIT_WRITE] && arm_cnt != 3'h0 && !ee_busy) begin
            next_wr_pend   = 1'b1; // R11 R13
            next_arm_cnt   = 3'h0;
            next_stall_cnt = 3'(DSE_WR_STALL); // R9
          end
          if (req.wdata[DSE_BIT_READ] && !ee_busy) begin
            ee_rd          = 1'b1; // R15
            next_rd_pend   = 1'b1;
            next_stall_cnt = 3'(DSE_RD_STALL); // R9
          end
        end
        DSE_IO_DATA:    next_ee_data = req.wdata;
        DSE_IO_ADDR_LO: if (!ee_busy) next_ee_addr[7:0] = req.wdata; // R15 R16
        DSE_IO_ADDR_HI: if (!ee_busy) next_ee_addr[8] = req.wdata[0]; // R12 R15
        default:        next_ee_data = ee_data;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase     <= 1'b0;
      done      <= 1'b0;
      rdata     <= 8'h00;
      ee_data   <= DSE_DATA_RESET;
      ee_addr   <= 9'h000;
      arm_cnt   <= 3'h0;
      stall_cnt <= 3'h0;
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      stall     <= 1'b0;
      ee_busy   <= 1'b0;
      ptr_we    <= 1'b0;
      ptr_sel   <= DSE_PTR_X;
      ptr_val   <= 16'h0000;
      ext_we    <= 1'b0;
      ext_addr  <= 8'h00;
      ext_wdata <= 8'h00;
    end else begin
      phase     <= next_phase;
      done      <= next_done;
      rdata     <= next_rdata;
      ee_data   <= next_ee_data;
      ee_addr   <= next_ee_addr;
      arm_cnt   <= next_arm_cnt;
      stall_cnt <= next_stall_cnt;
      wr_pend   <= next_wr_pend;
      rd_pend   <= next_rd_pend;
      stall     <= (next_stall_cnt != 3'h0); // R9
      ee_busy   <= arr_busy || next_wr_pend || ee_wr; // R14
      ptr_we    <= next_done && (req.mode == DSE_AM_PREDEC || req.mode == DSE_AM_POSTINC); // R4
      ptr_sel   <= req.ptr;
      ptr_val   <= ptr_new;
      ext_we    <= next_done && req.write && (hit_ext || hit_extio) && !hit_ee;
      ext_addr  <= ea[7:0];
      ext_wdata <= req.wdata;
    end
  end

  // SRAM; writes beyond its end are dropped
  always_ff @(posedge clk) begin
    if (next_done && req.write && hit_sram) begin
      sram[10'(ea - DSE_SRAM_BASE)] <= req.wdata; // R6 R17
    end
  end

  dse_eeprom #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_eeprom (
    .clk   (clk),
    .nrst  (nrst),
    .addr  (ee_addr),
    .rd    (ee_rd),
    .wr    (ee_wr),
    .wdata (ee_data),
    .rdata (ee_rdata),
    .busy  (arr_busy)
  );

  sequence arm_set_s;
    io_we && io_off == DSE_IO_CTRL && req.wdata[DSE_BIT_ARM] && !req.wdata[DSE_BIT_WRITE];
  endsequence
  sequence arm_gone_s;
    ##5 (arm_cnt == 3'h0);
  endsequence

  arm_timeout_a: assert property (@(posedge clk) disable iff (!nrst)
    arm_set_s |-> arm_gone_s) else $error("Arm bit did not expire after four cycles"); // R13
  rd_stall_a: assert property (@(posedge clk) disable iff (!nrst)
    (ee_rd && !ee_wr && next_stall_cnt == 3'h4) |=> stall [*4] ##1 !stall) else $error("Read stall length wrong"); // R9
  wr_stall_a: assert property (@(posedge clk) disable iff (!nrst)
    (io_we && !ee_rd && next_wr_pend && !wr_pend) |=> stall [*2] ##1 !stall) else $error("Write stall length wrong"); // R9
  no_arm_a: assert property (@(posedge clk) disable iff (!nrst)
    (ee_wr) |-> $past(arm_cnt != 3'h0) && $past(io_we)) else $error("Write began without arm sequence"); // R13
  addr_frozen_a: assert property (@(posedge clk) disable iff (!nrst)
    (ee_busy && $past(ee_busy)) |-> $stable(ee_addr)) else $error("Address changed during programming"); // R15
  sram_two_a: assert property (@(posedge clk) disable iff (!nrst)
    (req.valid && hit_sram && !phase && !done && stall_cnt == 3'h0) |=> phase ##1 done) else $error("SRAM not two cycles"); // R6
  unmapped_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (next_done && !req.write && !hit_ext && !hit_extio && !hit_sram) |=> rdata == 8'h00) else $error("Unmapped read not zero"); // R17
  hi_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (next_done && !req.write && hit_ee && io_off == DSE_IO_ADDR_HI) |=> rdata[7:1] == 7'h00) else $error("Reserved address bits not zero"); // R12
  ptr_back_a: assert property (@(posedge clk) disable iff (!nrst)
    (next_done && req.mode == DSE_AM_POSTINC) |=> ptr_we && ptr_val == $past(base) + 16'h0001) else $error("Post-increment write-back wrong"); // R4
endmodule // dse_top

// ---- dse_top_bench.sv ----
// Self-checking bench for dse_top: data-space decode, SRAM and EEPROM access.
// Assumes the register file model on the ext_* ports and a short programming time.
`timescale 1ns/1ps
module dse_top_bench;
  import dse_pkg::*;
  localparam logic [15:0] sram_last = DSE_SRAM_BASE + 16'(DSE_SRAM_BYTES) - 16'h0001;
  localparam logic [15:0] a_ctrl    = DSE_STDIO_BASE + {10'h000, DSE_IO_CTRL};
  localparam logic [15:0] a_data    = DSE_STDIO_BASE + {10'h000, DSE_IO_DATA};
  localparam logic [15:0] a_lo      = DSE_STDIO_BASE + {10'h000, DSE_IO_ADDR_LO};
  localparam logic [15:0] a_hi      = DSE_STDIO_BASE + {10'h000, DSE_IO_ADDR_HI};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  dse_req_type req = '0;
  logic [15:0] ptr_x = '0;
  logic [15:0] ptr_y = '0;
  logic [15:0] ptr_z = '0;
  logic [7:0]  rdata, ext_addr, ext_wdata, ext_rdata;
  logic        done, stall, ptr_we, ext_we, ee_busy, got_we;
  dse_ptr_type ptr_sel, got_ps;
  logic [15:0] ptr_val, got, got_pv;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          lat, st;

  dse_top #(.PROG_CYCLES(20)) i_dut (.clk(clk), .nrst(nrst), .req(req), .ptr_x(ptr_x), .ptr_y(ptr_y),
    .ptr_z(ptr_z), .rdata(rdata), .done(done), .stall(stall), .ptr_we(ptr_we), .ptr_sel(ptr_sel),
    .ptr_val(ptr_val), .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata), .ee_busy(ee_busy));
  dse_regfile_model i_rf (.clk(clk), .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata));

  always #25 clk = ~clk;
  // A hung handshake ends here rather than running forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_n(input int g, input int e);
    chk(16'(g), 16'(e));
  endtask

  // Request held until done is seen, then dropped; next one only after stall falls
  task automatic acc(input logic w, input logic s, input dse_mode_type m, input dse_ptr_type p,
                     input logic [15:0] a, input logic [5:0] d, input logic [7:0] wd);
    @(posedge clk);
    req <= '{valid: 1'b1, write: w, short_io: s, mode: m, ptr: p, addr: a, disp: d, wdata: wd};
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (done !== 1'b1 && lat < 40);
    lat = lat - 1;
    got = {8'h00, rdata};
    got_we = ptr_we;
    got_ps = ptr_sel;
    got_pv = ptr_val;
    req.valid <= 1'b0;
    st = 0;
    while (stall === 1'b1 && st < 40) begin
      st++;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] wd);
    acc(1'b1, 1'b0, DSE_AM_DIRECT, DSE_PTR_X, a, 6'h00, wd);
  endtask

  task automatic rd(input logic [15:0] a);
    acc(1'b0, 1'b0, DSE_AM_DIRECT, DSE_PTR_X, a, 6'h00, 8'h00);
  endtask

  task automatic wait_idle();
    int n = 0;
    while (ee_busy !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk({15'h0, ee_busy}, 16'h0000);
  endtask

  task automatic ee_rd(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] e);
    wr(a_hi, hi);
    wr(a_lo, lo);
    wr(a_ctrl, 8'h01);
    chk_n(st, DSE_RD_STALL);
    rd(a_data);
    chk(got, {8'h00, e});
  endtask

  task automatic t_map();
    wr(16'h0005, 8'h11);
    chk_n(lat, 1);
    wr(DSE_STDIO_BASE + 16'h0010, 8'h22);
    wr(DSE_EXTIO_BASE + 16'h0020, 8'h33);
    wr(DSE_SRAM_BASE, 8'h44);
    chk_n(lat, DSE_SRAM_CYC);
    wr(sram_last, 8'h55);
    wr(sram_last + 16'h0001, 8'h66);
    rd(16'h0005);
    chk(got, 16'h0011);
    rd(DSE_STDIO_BASE + 16'h0010);
    chk(got, 16'h0022);
    rd(DSE_EXTIO_BASE + 16'h0020);
    chk(got, 16'h0033);
    rd(DSE_SRAM_BASE);
    chk(got, 16'h0044);
    chk_n(lat, DSE_SRAM_CYC);
    rd(sram_last);
    chk(got, 16'h0055);
    rd(sram_last + 16'h0001);
    chk(got, 16'h0000);
  endtask

  task automatic t_short();
    acc(1'b1, 1'b1, DSE_AM_DIRECT, DSE_PTR_X, DSE_EXTIO_BASE + 16'h0020, 6'h00, 8'hc3);
    rd(DSE_EXTIO_BASE + 16'h0020);
    chk(got, 16'h0033);
    rd(DSE_STDIO_BASE);
    chk(got, 16'h00c3);
    acc(1'b0, 1'b1, DSE_AM_DIRECT, DSE_PTR_X, 16'h0010, 6'h00, 8'h00);
    chk(got, 16'h0022);
  endtask

  task automatic t_ind();
    ptr_x <= 16'h0300;
    ptr_y <= 16'h0200;
    ptr_z <= 16'h0300;
    acc(1'b1, 1'b0, DSE_AM_DISP, DSE_PTR_Y, 16'h0000, DSE_DISP_MAX, 8'h77);
    rd(16'h0200 + {10'h000, DSE_DISP_MAX});
    chk(got, 16'h0077);
    acc(1'b1, 1'b0, DSE_AM_PREDEC, DSE_PTR_X, 16'h0000, 6'h00, 8'h88);
    chk({15'h0, got_we}, 16'h0001);
    chk({14'h0, got_ps}, {14'h0, DSE_PTR_X});
    chk(got_pv, 16'h02ff);
    rd(16'h02ff);
    chk(got, 16'h0088);
    wr(16'h0300, 8'h99);
    acc(1'b0, 1'b0, DSE_AM_POSTINC, DSE_PTR_Z, 16'h0000, 6'h00, 8'h00);
    chk(got, 16'h0099);
    chk({14'h0, got_ps}, {14'h0, DSE_PTR_Z});
    chk(got_pv, 16'h0301);
  endtask

  task automatic t_ee();
    rd(a_ctrl);
    chk(got, {8'h00, DSE_CTRL_RESET});
    rd(a_data);
    chk(got, {8'h00, DSE_DATA_RESET});
    wr(a_hi, 8'hff);
    rd(a_hi);
    chk(got, 16'h0001);
    wr(a_lo, 8'hff);
    wr(a_data, 8'ha5);
    wr(a_ctrl, 8'h04);
    wr(a_ctrl, 8'h02);
    chk_n(st, DSE_WR_STALL);
    chk({15'h0, ee_busy}, 16'h0001);
    wr(a_lo, 8'h00);
    rd(a_lo);
    chk(got, 16'h00ff);
    rd(a_ctrl);
    chk(got & 16'h0002, 16'h0002);
    wait_idle();
    rd(a_ctrl);
    chk(got & 16'h0002, 16'h0000);
    wr(a_data, 8'h00);
    ee_rd(8'h01, 8'hff, 8'ha5);
  endtask

  task automatic t_guard();
    wr(a_hi, 8'h00);
    wr(a_lo, 8'h00);
    wr(a_data, 8'h3c);
    wr(a_ctrl, 8'h02);
    chk({15'h0, ee_busy}, 16'h0000);
    wr(a_ctrl, 8'h04);
    repeat (DSE_ARM_CYCLES) @(posedge clk);
    rd(a_ctrl);
    chk(got & 16'h0004, 16'h0000);
    wr(a_ctrl, 8'h02);
    chk({15'h0, ee_busy}, 16'h0000);
    wr(a_ctrl, 8'h04);
    wr(a_ctrl, 8'h02);
    chk({15'h0, ee_busy}, 16'h0001);
    wait_idle();
    ee_rd(8'h00, 8'h00, 8'h3c);
    ee_rd(8'h01, 8'hff, 8'ha5);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_map();
    t_short();
    t_ind();
    t_ee();
    t_guard();
    report_and_stop();
  end
endmodule // dse_top_bench
